// ===== shared/gdi_regs.vh
// constants and register map of the instrument bus interface
`ifndef GDI_REGS_VH
`define GDI_REGS_VH

// ----------------------------------------------
// register offsets
// ----------------------------------------------
`define GDI_A_CTRL     5'h00
`define GDI_A_STAT     5'h04
`define GDI_A_SET0     5'h08
`define GDI_A_SET1     5'h0c
`define GDI_A_STB      5'h10
`define GDI_A_RXD      5'h14
`define GDI_A_TXD      5'h18

// ----------------------------------------------
// fields and reset values
// ----------------------------------------------
`define GDI_CTRL_TONLY 5
`define GDI_ADDR_DEF   5'h1b
`define GDI_SET0_DEF   32'h00039880
`define GDI_SET1_DEF   32'h000a0d00
`define GDI_TRIG_LSB   10
`define GDI_TRIG_MSB   12
`define GDI_TRIG_BUS1  3'h2
`define GDI_TRIG_BUS2  3'h3
`define GDI_RSV_BIT    6
`define GDI_TXD_EOI    8

// ----------------------------------------------
// bus commands, seven bits, parity ignored
// ----------------------------------------------
`define GDI_C_GTL      7'h01
`define GDI_C_SDC      7'h04
`define GDI_C_GET      7'h08
`define GDI_C_LLO      7'h11
`define GDI_C_DCL      7'h14
`define GDI_C_SPE      7'h18
`define GDI_C_SPD      7'h19
`define GDI_C_UNL      7'h3f
`define GDI_C_UNT      7'h5f
`define GDI_GRP_LAG    2'h1
`define GDI_GRP_TAG    2'h2

// ----------------------------------------------
// timing
// ----------------------------------------------
`define GDI_CLK_NS     20
`define GDI_T1_NS      2000
`define GDI_T1_CYC ((`GDI_T1_NS+`GDI_CLK_NS-1)/`GDI_CLK_NS)

`endif

// ===== logic/gdi_ah.v
// acceptor handshake for the bus interface
`timescale 1ns/100ps

module gdi_ah (
  input  wire       clk,
  input  wire       rstn,
  input  wire       active,
  input  wire       ready,
  input  wire       dav,
  input  wire [7:0] dio,
  output wire       nrfd,
  output wire       ndac,
  output reg        acc,
  output reg  [7:0] data
);

  localparam IDLE = 3'h0;
  localparam NRDY = 3'h1;
  localparam RDY  = 3'h2;
  localparam ACPT = 3'h3;
  localparam WNEW = 3'h4;

  reg [2:0] st_reg;
  reg [2:0] st_next;

  // ----------------------------------------------
  // handshake lines follow state
  // ----------------------------------------------
  assign nrfd = (st_reg == NRDY) | (st_reg == ACPT) |
                (st_reg == WNEW);
  assign ndac = (st_reg == NRDY) | (st_reg == RDY) |
                (st_reg == WNEW);

  always @* begin
    st_next = st_reg;
    case (st_reg)
      IDLE: if (active) st_next = NRDY;
      NRDY: begin
        if (!active) st_next = IDLE;
        else if (ready && !dav) st_next = RDY;
      end
      RDY: begin
        if (!active) st_next = IDLE;
        else if (dav) st_next = ACPT;
      end
      ACPT: if (!dav) st_next = WNEW;
      WNEW: st_next = NRDY;
      default: st_next = IDLE;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= IDLE;
      acc    <= 1'b0;
      data   <= 8'h00;
    end else begin
      st_reg <= st_next;
      acc    <= (st_reg == RDY) && active && dav;
      if ((st_reg == RDY) && active && dav) begin
        data <= dio;
      end
    end
  end

endmodule

// ===== logic/gdi_sh.v
// source handshake for the bus interface
`timescale 1ns/100ps
`include "gdi_regs.vh"

module gdi_sh (
  input  wire       clk,
  input  wire       rstn,
  input  wire       active,
  input  wire       valid,
  input  wire [7:0] din,
  input  wire       eoi_in,
  input  wire       nrfd,
  input  wire       ndac,
  output wire       dav,
  output wire       drive,
  output reg  [7:0] dout,
  output reg        eoi,
  output wire       take
);

  localparam IDLE = 2'h0;
  localparam SETL = 2'h1;
  localparam TRAN = 2'h2;
  localparam [31:0] T1_FULL = `GDI_T1_CYC;
  localparam [6:0]  T1C     = T1_FULL[6:0];

  reg [1:0] st_reg;
  reg [6:0] cnt_reg;

  assign take  = (st_reg == IDLE) & active & valid;
  assign dav   = (st_reg == TRAN);
  assign drive = (st_reg != IDLE);

  // ----------------------------------------------
  // settle, wait ready, then wait accepted
  // ----------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg  <= IDLE;
      cnt_reg <= 7'h00;
      dout    <= 8'h00;
      eoi     <= 1'b0;
    end else if (!active) begin
      // attention or unaddress aborts the byte
      st_reg <= IDLE;
      eoi    <= 1'b0;
    end else begin
      case (st_reg)
        IDLE: if (valid) begin
          dout    <= din;
          eoi     <= eoi_in;
          cnt_reg <= T1C;
          st_reg  <= SETL;
        end
        SETL: begin
          if (cnt_reg != 7'h00) cnt_reg <= cnt_reg - 7'h01;
          else if (!nrfd) st_reg <= TRAN;
        end
        TRAN: if (!ndac) begin
          st_reg <= IDLE;
          eoi    <= 1'b0;
        end
        default: st_reg <= IDLE;
      endcase
    end
  end

endmodule

// ===== logic/gdi_core.v
// instrument-side bus interface: addressing, remote/local, clears
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "gdi_regs.vh"

module gdi_core (
  input  wire        CORE_CLK,
  input  wire        RSTN,
  input  wire [4:0]  ADDR,
  input  wire [31:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output wire [31:0] RDATA,
  input  wire [7:0]  DIO_N_I,
  output wire [7:0]  DIO_N_O,
  output wire [7:0]  DIO_N_OE_N,
  input  wire        DAV_N_I,
  output wire        DAV_N_O,
  output wire        DAV_N_OE_N,
  input  wire        NRFD_N_I,
  output wire        NRFD_N_O,
  output wire        NRFD_N_OE_N,
  input  wire        NDAC_N_I,
  output wire        NDAC_N_O,
  output wire        NDAC_N_OE_N,
  input  wire        EOI_N_I,
  output wire        EOI_N_O,
  output wire        EOI_N_OE_N,
  input  wire        SRQ_N_I,
  output wire        SRQ_N_O,
  output wire        SRQ_N_OE_N,
  input  wire        ATN_N_I,
  input  wire        IFC_N_I,
  input  wire        REN_N_I,
  input  wire        LOCAL_KEY,
  output wire        REMOTE_LED,
  output wire        TALK_LED,
  output wire        LISTEN_LED,
  output wire        PANEL_LOCK,
  output wire        TRIGGER,
  output wire        DEV_CLEAR
);

  // ----------------------------------------------
  // helpers
  // ----------------------------------------------
  function addr_hit;
    input [6:0] cmd;
    input [1:0] grp;
    input [4:0] adr;
    begin
      addr_hit = (cmd[6:5] == grp) && (cmd[4:0] == adr);
    end
  endfunction

  function in_grp;
    input [6:0] cmd;
    input [1:0] grp;
    begin
      in_grp = (cmd[6:5] == grp);
    end
  endfunction

  // ----------------------------------------------
  // declarations
  // ----------------------------------------------
  reg         remote_reg;
  reg         remote_next;
  reg         lock_reg;
  reg         lock_next;
  reg         listen_reg;
  reg         listen_next;
  reg         talk_reg;
  reg         talk_next;
  reg         spoll_reg;
  reg         spoll_next;
  reg         polled_reg;
  reg         srq_reg;
  reg  [7:0]  stb_reg;
  reg  [5:0]  ctrl_reg;
  reg  [31:0] set0_reg;
  reg  [31:0] set1_reg;
  reg  [7:0]  rx_reg;
  reg         rx_eoi_reg;
  reg         rx_full_reg;
  reg  [8:0]  tx_reg;
  reg         tx_full_reg;
  reg  [31:0] rdata_reg;
  reg  [31:0] rdata_next;
  reg         trig_reg;
  reg         clr_reg;

  wire        atn;
  wire        ifc;
  wire        ren;
  wire        dav_in;
  wire        nrfd_in;
  wire        ndac_in;
  wire        eoi_in;
  wire [7:0]  dio_in;
  wire [4:0]  bus_addr;
  wire        talk_only;
  wire [2:0]  trig_mode;

  wire        ah_active;
  wire        ah_ready;
  wire        ah_nrfd;
  wire        ah_ndac;
  wire        ah_acc;
  wire [7:0]  ah_data;

  wire        sh_active;
  wire        sh_valid;
  wire [7:0]  sh_byte;
  wire        sh_eoi_in;
  wire        sh_dav;
  wire        sh_drive;
  wire [7:0]  sh_dout;
  wire        sh_eoi;
  wire        sh_take;

  wire [6:0]  cmd;
  wire        acc_cmd;
  wire        acc_dat;
  wire        my_lag;
  wire        my_tag;
  wire        oth_tag;
  wire        c_unl;
  wire        c_unt;
  wire        c_gtl;
  wire        c_llo;
  wire        c_dcl;
  wire        c_sdc;
  wire        c_get;
  wire        c_spe;
  wire        c_spd;
  wire        dev_clr;
  wire        bus_trig;
  wire [7:0]  poll_byte;
  wire        wr_stb;
  wire        wr_txd;
  wire        rd_rxd;

  // ----------------------------------------------
  // bus lines, true when pulled low
  // ----------------------------------------------
  assign atn       = ~ATN_N_I;
  assign ifc       = ~IFC_N_I;
  assign ren       = ~REN_N_I;
  assign dav_in    = ~DAV_N_I;
  assign nrfd_in   = ~NRFD_N_I;
  assign ndac_in   = ~NDAC_N_I;
  assign eoi_in    = ~EOI_N_I;
  assign dio_in    = ~DIO_N_I;

  assign bus_addr  = ctrl_reg[4:0];
  assign talk_only = ctrl_reg[`GDI_CTRL_TONLY];
  assign trig_mode = set0_reg[`GDI_TRIG_MSB:`GDI_TRIG_LSB];

  // ----------------------------------------------
  // handshakes
  // ----------------------------------------------
  // commands are taken whenever IFC is false; data only when a listener
  assign ah_active = ~ifc & (atn | listen_reg);
  // data waits while the holding byte is unread
  assign ah_ready  = atn | ~rx_full_reg;

  gdi_ah u_ah (
    .clk    (CORE_CLK),
    .rstn   (RSTN),
    .active (ah_active),
    .ready  (ah_ready),
    .dav    (dav_in),
    .dio    (dio_in),
    .nrfd   (ah_nrfd),
    .ndac   (ah_ndac),
    .acc    (ah_acc),
    .data   (ah_data)
  );

  assign sh_active = (talk_reg | talk_only) & ~atn & ~ifc;
  assign poll_byte = {stb_reg[7], srq_reg, stb_reg[5:0]};
  assign sh_valid  = spoll_reg ? ~polled_reg : tx_full_reg;
  assign sh_byte   = spoll_reg ? poll_byte : tx_reg[7:0];
  assign sh_eoi_in = ~spoll_reg & tx_reg[`GDI_TXD_EOI];

  gdi_sh u_sh (
    .clk    (CORE_CLK),
    .rstn   (RSTN),
    .active (sh_active),
    .valid  (sh_valid),
    .din    (sh_byte),
    .eoi_in (sh_eoi_in),
    .nrfd   (nrfd_in),
    .ndac   (ndac_in),
    .dav    (sh_dav),
    .drive  (sh_drive),
    .dout   (sh_dout),
    .eoi    (sh_eoi),
    .take   (sh_take)
  );

  // open drain: output low, enable low pulls the line
  assign DIO_N_O     = 8'h00;
  assign DIO_N_OE_N  = ~(sh_dout & {8{sh_drive}});
  assign DAV_N_O     = 1'b0;
  assign DAV_N_OE_N  = ~sh_dav;
  assign NRFD_N_O    = 1'b0;
  assign NRFD_N_OE_N = ~ah_nrfd;
  assign NDAC_N_O    = 1'b0;
  assign NDAC_N_OE_N = ~ah_ndac;
  // eoi under attention is identify; never answered
  assign EOI_N_O     = 1'b0;
  assign EOI_N_OE_N  = ~(sh_eoi & sh_drive & ~atn);
  assign SRQ_N_O     = 1'b0;
  assign SRQ_N_OE_N  = ~srq_reg;

  // ----------------------------------------------
  // command decode
  // ----------------------------------------------
  // secondaries, configure and control passing fall
  // through unmatched and are ignored
  assign cmd     = ah_data[6:0];
  assign acc_cmd = ah_acc & atn;
  assign acc_dat = ah_acc & ~atn;
  assign my_lag  = acc_cmd &
                   addr_hit(cmd, `GDI_GRP_LAG, bus_addr);
  assign my_tag  = acc_cmd &
                   addr_hit(cmd, `GDI_GRP_TAG, bus_addr);
  assign oth_tag = acc_cmd & in_grp(cmd, `GDI_GRP_TAG) &
                   ~addr_hit(cmd, `GDI_GRP_TAG, bus_addr);
  assign c_unl   = acc_cmd & (cmd == `GDI_C_UNL);
  assign c_unt   = acc_cmd & (cmd == `GDI_C_UNT);
  assign c_gtl   = acc_cmd & (cmd == `GDI_C_GTL);
  assign c_llo   = acc_cmd & (cmd == `GDI_C_LLO);
  assign c_dcl   = acc_cmd & (cmd == `GDI_C_DCL);
  assign c_sdc   = acc_cmd & (cmd == `GDI_C_SDC);
  assign c_get   = acc_cmd & (cmd == `GDI_C_GET);
  assign c_spe   = acc_cmd & (cmd == `GDI_C_SPE);
  assign c_spd   = acc_cmd & (cmd == `GDI_C_SPD);

  // universal clear for all, selective only when addressed
  assign dev_clr = c_dcl | (c_sdc & listen_reg);
  assign bus_trig = c_get & listen_reg &
                    ((trig_mode == `GDI_TRIG_BUS1) |
                     (trig_mode == `GDI_TRIG_BUS2));

  // ----------------------------------------------
  // remote, lockout and addressing
  // ----------------------------------------------
  always @* begin
    remote_next = remote_reg;
    lock_next   = lock_reg;
    listen_next = listen_reg;
    talk_next   = talk_reg;
    spoll_next  = spoll_reg;
    if (ifc) begin
      remote_next = 1'b0;
      listen_next = 1'b0;
      talk_next   = 1'b0;
      spoll_next  = 1'b0;
    end else begin
      if (my_lag) begin
        listen_next = 1'b1;
        talk_next   = 1'b0;
        if (ren) remote_next = 1'b1;
      end
      if (c_unl) listen_next = 1'b0;
      if (my_tag) begin
        talk_next   = 1'b1;
        listen_next = 1'b0;
      end
      if (oth_tag | c_unt) talk_next = 1'b0;
      if (c_gtl & listen_reg) remote_next = 1'b0;
      if (c_llo & ren) lock_next = 1'b1;
      if (c_spe) spoll_next = 1'b1;
      if (c_spd) spoll_next = 1'b0;
      // the panel local key is dead while locked out
      if (LOCAL_KEY & ~lock_reg) remote_next = 1'b0;
    end
    if (!ren) begin
      remote_next = 1'b0;
      lock_next   = 1'b0;
    end
  end

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      remote_reg <= 1'b0;
      lock_reg   <= 1'b0;
      listen_reg <= 1'b0;
      talk_reg   <= 1'b0;
      spoll_reg  <= 1'b0;
      trig_reg   <= 1'b0;
      clr_reg    <= 1'b0;
    end else begin
      remote_reg <= remote_next;
      lock_reg   <= lock_next;
      listen_reg <= listen_next;
      talk_reg   <= talk_next;
      spoll_reg  <= spoll_next;
      trig_reg   <= bus_trig;
      clr_reg    <= dev_clr;
    end
  end

  // ----------------------------------------------
  // settings, SET0 and SET1 restored by either clear; CTRL is not
  // ----------------------------------------------
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_reg <= {1'b0, `GDI_ADDR_DEF};
      set0_reg <= `GDI_SET0_DEF;
      set1_reg <= `GDI_SET1_DEF;
    end else begin
      if (WR && ADDR == `GDI_A_CTRL) ctrl_reg <= WDATA[5:0];
      // a clear beats a write in the same cycle
      if (dev_clr) begin
        set0_reg <= `GDI_SET0_DEF;
        set1_reg <= `GDI_SET1_DEF;
      end else begin
        if (WR && ADDR == `GDI_A_SET0) set0_reg <= WDATA;
        if (WR && ADDR == `GDI_A_SET1) set1_reg <= WDATA;
      end
    end
  end

  // ----------------------------------------------
  // status byte and serial poll
  // ----------------------------------------------
  assign wr_stb = WR && (ADDR == `GDI_A_STB);

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      stb_reg    <= 8'h00;
      srq_reg    <= 1'b0;
      polled_reg <= 1'b0;
    end else begin
      if (wr_stb) stb_reg <= WDATA[7:0];
      // a new request written while polled stays set
      if (wr_stb & WDATA[`GDI_RSV_BIT]) srq_reg <= 1'b1;
      else if (sh_take & spoll_reg) srq_reg <= 1'b0;
      if (c_spe) polled_reg <= 1'b0;
      else if (sh_take & spoll_reg) polled_reg <= 1'b1;
    end
  end

  // ----------------------------------------------
  // data holding bytes
  // ----------------------------------------------
  assign wr_txd = WR && (ADDR == `GDI_A_TXD);
  assign rd_rxd = RD && (ADDR == `GDI_A_RXD);

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_reg      <= 8'h00;
      rx_eoi_reg  <= 1'b0;
      rx_full_reg <= 1'b0;
      tx_reg      <= 9'h000;
      tx_full_reg <= 1'b0;
    end else begin
      if (acc_dat & listen_reg) begin
        rx_reg      <= ah_data;
        rx_eoi_reg  <= eoi_in;
        rx_full_reg <= 1'b1;
      end else if (rd_rxd) begin
        rx_full_reg <= 1'b0;
      end
      if (wr_txd) begin
        tx_reg      <= WDATA[8:0];
        tx_full_reg <= 1'b1;
      end else if (sh_take & ~spoll_reg) begin
        tx_full_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------
  // register read
  // ----------------------------------------------
  always @* begin
    rdata_next = 32'h00000000;
    case (ADDR)
      `GDI_A_CTRL: rdata_next = {26'h0, ctrl_reg};
      `GDI_A_STAT: rdata_next = {23'h0, ~SRQ_N_I,
                                 tx_full_reg, rx_full_reg,
                                 srq_reg, spoll_reg,
                                 talk_reg, listen_reg,
                                 lock_reg, remote_reg};
      `GDI_A_SET0: rdata_next = set0_reg;
      `GDI_A_SET1: rdata_next = set1_reg;
      `GDI_A_STB:  rdata_next = {24'h0, poll_byte};
      `GDI_A_RXD:  rdata_next = {22'h0, rx_full_reg,
                                 rx_eoi_reg, rx_reg};
      `GDI_A_TXD:  rdata_next = {23'h0, tx_reg};
      default:     rdata_next = 32'h00000000;
    endcase
  end

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_reg <= 32'h00000000;
    end else if (RD) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 32'h00000000;
    end
  end

  // ----------------------------------------------
  // outputs
  // ----------------------------------------------
  assign RDATA      = rdata_reg;
  assign REMOTE_LED = remote_reg;
  assign TALK_LED   = talk_reg | talk_only;
  assign LISTEN_LED = listen_reg;
  assign PANEL_LOCK = lock_reg;
  assign TRIGGER    = trig_reg;
  assign DEV_CLEAR  = clr_reg;

endmodule

// ===== tb/gdi_chk_assertions.sv
// port assertions for the instrument bus interface
`timescale 1ns/100ps

module gdi_chk (
  input wire       CORE_CLK,
  input wire       RSTN,
  input wire [7:0] DIO_N_OE_N,
  input wire       DAV_N_I,
  input wire       DAV_N_OE_N,
  input wire       NRFD_N_I,
  input wire       NDAC_N_OE_N,
  input wire       ATN_N_I,
  input wire       IFC_N_I,
  input wire       REN_N_I,
  input wire       LOCAL_KEY,
  input wire       REMOTE_LED,
  input wire       TALK_LED,
  input wire       LISTEN_LED,
  input wire       PANEL_LOCK,
  input wire       TRIGGER
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_dav_up;
    $fell(DAV_N_OE_N);
  endsequence
  // atn held a while, so a release can only answer a strobe
  sequence s_ndac_free;
    $rose(NDAC_N_OE_N) ##0 IFC_N_I ##0 !ATN_N_I ##0 !$past(ATN_N_I, 2);
  endsequence

  AST_REM_REN: assert property ($rose(REMOTE_LED) |-> !REN_N_I)
    else $error("remote entered without remote enable");
  AST_REM_LSN: assert property ($rose(REMOTE_LED) |-> LISTEN_LED)
    else $error("remote entered without listen address");
  AST_IFC_IDLE: assert property (
    !IFC_N_I |-> ##[1:4] (!REMOTE_LED && !LISTEN_LED))
    else $error("interface clear left remote or listen");
  AST_LOCK_REN: assert property ($rose(PANEL_LOCK) |-> !REN_N_I)
    else $error("lockout taken without remote enable");
  AST_KEY_LOCKED: assert property (
    PANEL_LOCK && REMOTE_LED && LOCAL_KEY && IFC_N_I |=> REMOTE_LED)
    else $error("panel key obeyed under lockout");
  AST_LOCK_KEEP: assert property (
    PANEL_LOCK && !REN_N_I |=> PANEL_LOCK)
    else $error("lockout dropped while remote enable true");
  AST_LOCK_FREE: assert property (
    $rose(REN_N_I) |-> ##[1:4] !PANEL_LOCK)
    else $error("lockout kept after remote enable false");
  AST_TRIG_LSN: assert property (TRIGGER |-> LISTEN_LED)
    else $error("trigger while not addressed");
  AST_TALK_LSN: assert property (!(TALK_LED && LISTEN_LED))
    else $error("talker and listener at once");
  AST_DRIVE_TALK: assert property (
    DIO_N_OE_N != 8'hff |-> TALK_LED)
    else $error("data driven while not talker");
  AST_DAV_SETTLED: assert property (
    s_dav_up |-> $past(NRFD_N_I) && $stable(DIO_N_OE_N))
    else $error("data valid before ready or with moving data");
  AST_NDAC_DAV: assert property (s_ndac_free |-> !DAV_N_I)
    else $error("byte accepted without data valid");
endmodule

// ===== tb/gdi_ctl_model.sv
// bus controller model: commands, data bytes, poll listener
`timescale 1ns/100ps

module gdi_ctl_model (
  input  wire       clk,
  input  wire [7:0] dio_n,
  input  wire       dav_n,
  input  wire       nrfd_n,
  input  wire       ndac_n,
  output reg        atn_n,
  output reg        ifc_n,
  output reg        ren_n,
  output reg  [7:0] dio_pull,
  output reg        dav_pull,
  output reg        nrfd_pull,
  output reg        ndac_pull,
  output reg        got,
  output reg  [7:0] got_byte
);
  integer errs;

  initial begin
    errs = 0;
    atn_n = 1'b1;
    ifc_n = 1'b1;
    ren_n = 1'b1;
    dio_pull = 8'h00;
    dav_pull = 1'b0;
    nrfd_pull = 1'b0;
    ndac_pull = 1'b0;
    got = 1'b0;
    got_byte = 8'h00;
  end

  // bounded wait on one handshake line, s: 0 dav, 1 nrfd, 2 ndac
  task wt(input [1:0] s, input v);
    integer n;
    reg     l;
    begin
      for (n = 0; n < 400; n = n + 1) begin
        l = (s == 2'd0) ? dav_n : (s == 2'd1) ? nrfd_n : ndac_n;
        if (l === v)
          n = 500;
        else
          @(posedge clk);
      end
      if (n == 400)
        errs = errs + 1;
    end
  endtask

  task lines(input r, input f);
    begin
      ren_n <= ~r;
      ifc_n <= ~f;
      repeat (4) @(posedge clk);
    end
  endtask

  task send(input a, input [7:0] b);
    begin
      atn_n <= ~a;
      dio_pull <= b;
      repeat (2) @(posedge clk);
      wt(2'd1, 1'b1);
      dav_pull <= 1'b1;
      @(posedge clk);
      wt(2'd2, 1'b1);
      dav_pull <= 1'b0;
      dio_pull <= 8'h00;
      @(posedge clk);
    end
  endtask

  // slow listener holds off ready to stall the talker
  task recv(input slow);
    begin
      atn_n <= 1'b1;
      ndac_pull <= 1'b1;
      nrfd_pull <= 1'b1;
      repeat (slow ? 150 : 1) @(posedge clk);
      nrfd_pull <= 1'b0;
      wt(2'd0, 1'b0);
      got_byte <= ~dio_n;
      got <= 1'b1;
      nrfd_pull <= 1'b1;
      ndac_pull <= 1'b0;
      @(posedge clk);
      got <= 1'b0;
      wt(2'd0, 1'b1);
      nrfd_pull <= 1'b0;
    end
  endtask
endmodule

// ===== tb/gpib_device_interface_functions_bench.sv
// self-checking bench for the instrument bus interface
`timescale 1ns/100ps
`include "gdi_regs.vh"

module gpib_device_interface_functions_bench;
  reg         clk;
  reg         rstn;
  reg  [4:0]  addr;
  reg  [31:0] wdata;
  reg         wr;
  reg         rd;
  reg         rd_q;
  reg         key;
  reg  [31:0] v;
  reg  [31:0] r;
  reg  [31:0] exp_q[$];
  reg  [31:0] msk_q[$];
  wire [31:0] rdata;
  wire [7:0]  dio_oe_n;
  wire [7:0]  dio_pull;
  wire        dav_oe_n;
  wire        nrfd_oe_n;
  wire        ndac_oe_n;
  wire        eoi_oe_n;
  wire        srq_oe_n;
  wire        dav_pull;
  wire        nrfd_pull;
  wire        ndac_pull;
  wire        atn_n;
  wire        ifc_n;
  wire        ren_n;
  wire        got;
  wire [7:0]  got_byte;
  wire        trig;
  wire        dclr;
  wire [7:0]  dio_n = dio_oe_n & ~dio_pull;
  wire        dav_n = dav_oe_n & ~dav_pull;
  wire        nrfd_n = nrfd_oe_n & ~nrfd_pull;
  wire        ndac_n = ndac_oe_n & ~ndac_pull;
  integer     fails;
  integer     check_count;
  integer     seed;
  integer     i;
  integer     trig_cnt;
  integer     clr_cnt;

  gdi_core gdi_core_inst (
    .CORE_CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .DIO_N_I(dio_n), .DIO_N_O(),
    .DIO_N_OE_N(dio_oe_n), .DAV_N_I(dav_n), .DAV_N_O(),
    .DAV_N_OE_N(dav_oe_n), .NRFD_N_I(nrfd_n), .NRFD_N_O(),
    .NRFD_N_OE_N(nrfd_oe_n), .NDAC_N_I(ndac_n), .NDAC_N_O(),
    .NDAC_N_OE_N(ndac_oe_n), .EOI_N_I(eoi_oe_n), .EOI_N_O(),
    .EOI_N_OE_N(eoi_oe_n), .SRQ_N_I(srq_oe_n), .SRQ_N_O(),
    .SRQ_N_OE_N(srq_oe_n), .ATN_N_I(atn_n), .IFC_N_I(ifc_n),
    .REN_N_I(ren_n), .LOCAL_KEY(key), .REMOTE_LED(), .TALK_LED(),
    .LISTEN_LED(), .PANEL_LOCK(), .TRIGGER(trig), .DEV_CLEAR(dclr));

  gdi_ctl_model ctl (
    .clk(clk), .dio_n(dio_n), .dav_n(dav_n), .nrfd_n(nrfd_n),
    .ndac_n(ndac_n), .atn_n(atn_n), .ifc_n(ifc_n), .ren_n(ren_n),
    .dio_pull(dio_pull), .dav_pull(dav_pull), .nrfd_pull(nrfd_pull),
    .ndac_pull(ndac_pull), .got(got), .got_byte(got_byte));

  task close_out;
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  task chk(input [31:0] g, input [31:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask

  task wreg(input [4:0] a, input [31:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask

  task rreg(input [4:0] a, input [31:0] e, input [31:0] m);
    begin
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
    end
  endtask

  task cmd(input [7:0] b);
    begin
      ctl.send(1'b1, b);
    end
  endtask

  // results are compared mid-cycle, away from the launching edge
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) begin
    trig_cnt = trig_cnt + trig;
    clr_cnt = clr_cnt + dclr;
    if (rd_q || got) begin
      r = rd_q ? rdata : {24'h0, got_byte};
      chk(r & msk_q.pop_front(), exp_q.pop_front());
    end
    if (ctl.errs != 0) begin
      fails = fails + 1;
      close_out;
    end
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    rstn = 1'b0;
    addr = 5'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    key = 1'b0;
    fails = 0;
    check_count = 0;
    seed = 67156;
    trig_cnt = 0;
    clr_cnt = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rreg(`GDI_A_CTRL, 32'h1b, 32'h3f);
    rreg(`GDI_A_SET0, `GDI_SET0_DEF, 32'hffffffff);
    rreg(`GDI_A_SET1, `GDI_SET1_DEF, 32'hffffffff);
    ctl.lines(1'b1, 1'b0);
    rreg(`GDI_A_STAT, 32'h00, 32'h3f);
    cmd(8'h3b);
    rreg(`GDI_A_STAT, 32'h05, 32'h3f);
    cmd(`GDI_C_LLO);
    key <= 1'b1;
    repeat (3) @(posedge clk);
    key <= 1'b0;
    rreg(`GDI_A_STAT, 32'h07, 32'h3f);
    cmd(`GDI_C_GTL);
    rreg(`GDI_A_STAT, 32'h06, 32'h3f);
    v = $random(seed) & 32'hfffff;
    wreg(`GDI_A_SET0, v);
    cmd(`GDI_C_DCL);
    rreg(`GDI_A_SET0, `GDI_SET0_DEF, 32'hffffffff);
    rreg(`GDI_A_STAT, 32'h06, 32'h3f);
    cmd(`GDI_C_UNL);
    wreg(`GDI_A_SET0, v);
    cmd(`GDI_C_SDC);
    rreg(`GDI_A_SET0, v, 32'hfffff);
    cmd(8'h3b);
    cmd(`GDI_C_SDC);
    rreg(`GDI_A_SET0, `GDI_SET0_DEF, 32'hffffffff);
    chk(clr_cnt, 2);
    ctl.lines(1'b0, 1'b0);
    rreg(`GDI_A_STAT, 32'h04, 32'h3f);
    // last pass: bus mode but no longer addressed
    for (i = 0; i < 9; i = i + 1) begin
      v = (i == 8) ? 2 : i;
      wreg(`GDI_A_SET0, v << `GDI_TRIG_LSB);
      if (i == 8)
        cmd(`GDI_C_UNL);
      cmd(`GDI_C_GET);
    end
    chk(trig_cnt, 2);
    cmd(8'h05);
    cmd(8'h7b);
    rreg(`GDI_A_STAT, 32'h00, 32'h3f);
    cmd(8'h3b);
    cmd(8'h5b);
    rreg(`GDI_A_STAT, 32'h08, 32'h3f);
    cmd(8'h3b);
    rreg(`GDI_A_STAT, 32'h04, 32'h3f);
    ctl.lines(1'b1, 1'b0);
    cmd(8'h3b);
    ctl.lines(1'b1, 1'b1);
    ctl.lines(1'b1, 1'b0);
    rreg(`GDI_A_STAT, 32'h00, 32'h3f);
    v = $random(seed);
    ctl.send(1'b0, v[7:0]);
    rreg(`GDI_A_RXD, 32'h000, 32'h200);
    cmd(8'h3b);
    ctl.send(1'b0, v[7:0]);
    rreg(`GDI_A_RXD, 32'h200 | v[7:0], 32'h2ff);
    for (i = 0; i < 2; i = i + 1) begin
      v = $random(seed) & 32'hff;
      v[6] = i[0];
      wreg(`GDI_A_STB, v);
      @(negedge clk);
      chk(srq_oe_n, !i[0]);
      @(posedge clk);
      cmd(`GDI_C_SPE);
      cmd(8'h5b);
      exp_q.push_back(v);
      msk_q.push_back(32'hff);
      ctl.recv(i[0]);
      cmd(`GDI_C_SPD);
      rreg(`GDI_A_STAT, 32'h09, 32'h3f);
      chk(srq_oe_n, 1'b1);
    end
    // still talker with attention held: a data byte waits
    v = $random(seed) & 32'h1ff;
    wreg(`GDI_A_TXD, v);
    exp_q.push_back(v & 32'hff);
    msk_q.push_back(32'hff);
    ctl.recv(1'b0);
    close_out;
  end
endmodule

bind gdi_core gdi_chk gdi_chk_inst (
  .CORE_CLK, .RSTN, .DIO_N_OE_N, .DAV_N_I, .DAV_N_OE_N, .NRFD_N_I,
  .NDAC_N_OE_N, .ATN_N_I, .IFC_N_I, .REN_N_I, .LOCAL_KEY, .REMOTE_LED,
  .TALK_LED, .LISTEN_LED, .PANEL_LOCK, .TRIGGER);
